// *** axis_capture_checker_asserts.sv ***
// Concurrent checks on the ports of the axis capture and switch block
`timescale 1ns/1ps

module axis_capture_checker #(
  parameter SERVO_CYCLES = 8
) (
  input wire        clk_sys,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [3:0]  enc_a,
  input wire [3:0]  enc_b,
  input wire [3:0]  enc_z,
  input wire [3:0]  registration_in,
  input wire [3:0]  registration_level,
  input wire [3:0]  capture_flag,
  input wire [31:0] switch_out
);
  reg [7:0]  quiet_r;
  reg [7:0]  pins_r;
  reg [31:0] out_r;
  reg [31:0] gap_r;
  reg        seen_r;

  // Cycles since a trigger pin moved, and since the outputs last changed
  always @(posedge clk_sys) begin
    pins_r <= {enc_z, registration_in};
    out_r <= switch_out;
    if (rst) begin
      quiet_r <= 8'h00;
      gap_r <= 32'h0;
      seen_r <= 1'b0;
    end else begin
      quiet_r <= ({enc_z, registration_in} != pins_r) ? 8'h00 :
                 (quiet_r == 8'hff) ? quiet_r : quiet_r + 8'h01;
      gap_r <= (switch_out != out_r) ? 32'h1 : gap_r + 32'h1;
      seen_r <= seen_r | (switch_out != out_r);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_ready_const: assert property (pready) else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  a_err_gap: assert property (psel && penable && paddr >= 12'h0a0 && paddr < 12'h100
    |-> pslverr) else $error("hole not refused");
  a_err_axis_ok: assert property (psel && penable && paddr < 12'h08c |-> !pslverr)
    else $error("mapped word refused");
  a_rdata_hold: assert property (!psel |=> $stable(prdata)) else $error("prdata moved");
  a_write_rzero: assert property (psel && !penable && pwrite |=> prdata == 32'h0)
    else $error("write read data not zero");
  a_gap_rzero: assert property (psel && !penable && paddr >= 12'h0a0 && paddr < 12'h100
    |=> prdata == 32'h0) else $error("hole read not zero");
  a_flag_cause: assert property (quiet_r > 8'h06 |-> (capture_flag & ~$past(capture_flag)) == 4'h0)
    else $error("flag without pin edge");
  a_switch_tick: assert property (seen_r && switch_out != out_r |-> gap_r % SERVO_CYCLES == 0)
    else $error("output change off the servo tick");

  c_refused: cover property (pslverr);
  c_capture: cover property ((capture_flag & ~$past(capture_flag)) != 4'h0);
  c_switched: cover property (switch_out != out_r);
endmodule // axis_capture_checker

// *** axis_capture_map.vh ***
// Register map, field positions, reset values and timing for the axis capture block
`ifndef AXIS_CAPTURE_MAP_VH
`define AXIS_CAPTURE_MAP_VH

// Per-axis block: axis n at byte n*0x20, offsets within the block
`define AX_UNITS      5'h00
`define AX_WDIST      5'h04
`define AX_WEN        5'h08
`define AX_POS        5'h0c
`define AX_WOPEN      5'h10
`define AX_WCLOSE     5'h14
`define AX_CAPPOS     5'h18
`define AX_STAT       5'h1c
`define AX_END        12'h080

// Global registers
`define G_DEFAXIS     12'h080
`define G_ARM         12'h084
`define G_OUTS        12'h088
`define G_RAW_BASE    12'h090
`define G_RAW_END     12'h0a0

// Position switches: switch n at 0x100 + n*0x10
`define SW_BASE       12'h100
`define SW_END        12'h200
`define SW_CTRL       4'h0
`define SW_ON         4'h4
`define SW_OFF        4'h8

// Arm register fields
`define ARM_MODE_LO   0
`define ARM_BASE_W    3
`define ARM_WIN_LO    8
`define ARM_AXIS_LO   12
`define ARM_TEMP_BIT  16

// Switch control fields
`define SWC_EN        0
`define SWC_LVL       1
`define SWC_AXIS_LO   4
`define SWC_OUT_LO    8

// Axis status fields
`define ST_FLAG       0
`define ST_ARMED      1

// Base capture modes and window selections
`define MODE_Z_RISE   3'h1
`define MODE_Z_FALL   3'h2
`define MODE_R_RISE   3'h3
`define MODE_R_FALL   3'h4
`define WIN_INCL      2'h1
`define WIN_EXCL      2'h3

// Reset values
`define UNITS_RST     32'h00000001
`define ZERO32        32'h00000000

// Servo cycle timing
`define SERVO_PERIOD_NS 1000000
`define CLK_PERIOD_NS   40

`endif

// *** axis_position_capture_and_switch.v ***
// Axis position counting, position switches and registration capture with APB access
// Notes on behaviour
// [R1] Each switch holds an on or off level applied to its output while active.
// [R2] Output goes to the configured level when axis position reaches turn-on position.
// [R3] Output is released when axis position reaches turn-off position.
// [R4] Only an enabled switch acts; a disabled switch leaves its output alone.
// [R5] Switch positions compare in user units, edges scaled by per-axis unit factor.
// [R6] Position counter steps once per quadrature edge, four counts per encoder line.
// [R7] An armed capture latches position on registration input or index marker.
// [R8] The latch is taken in hardware at the detected edge itself.
// [R9] A qualifying event inside the window sets the flag and stores the position.
// [R10] Captured position is in user units and read-only.
// [R11] Registration inputs zero to three belong to axes zero to three.
// [R12] Registration inputs stay available to other functions such as datum sensing.
// [R13] Capture arms the default axis unless a temporary axis is given.
// [R14] Mode plus 256: accept only between window open and close limits.
// [R15] Mode plus 768: accept only below open limit or above close limit.
// [R16] Base modes: 1 index rise, 2 index fall, 3 input rise, 4 input fall.
// [R17] Controller re-arms for every capture; one arming gives at most one capture.
// [R18] Sixteen switches, each with own axis, on, off positions and output.
// [R19] All switches evaluate once per servo cycle and update outputs.
// [R20] Arming clears the capture flag; a capture in the arming cycle sets it instead.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "axis_capture_map.vh"

module axis_position_capture_and_switch #(
  parameter AXES         = 4,
  parameter SWITCHES     = 16,
  parameter SERVO_CYCLES = `SERVO_PERIOD_NS / `CLK_PERIOD_NS
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [3:0]  enc_a,
  input  wire [3:0]  enc_b,
  input  wire [3:0]  enc_z,
  input  wire [3:0]  registration_in,
  output wire [3:0]  registration_level,
  output wire [3:0]  capture_flag,
  output wire [31:0] switch_out
);

  localparam [31:0] SERVO_LAST = SERVO_CYCLES - 1;

  integer i;

  // Input synchronisers: a, b, z and registration, four bits each
  reg  [15:0] sync1_r;
  reg  [15:0] sync2_r;
  reg  [15:0] prev_r;
  wire [15:0] in_raw;

  // Per-axis configuration and state
  reg  [31:0] units_r   [0:3];
  reg  [31:0] wdist_r   [0:3];
  reg  [31:0] wopen_r   [0:3];
  reg  [31:0] wclose_r  [0:3];
  reg  [31:0] cap_pos_r [0:3];
  reg  [31:0] upos_r    [0:3];
  reg  [31:0] rem_r     [0:3];
  reg  [31:0] raw_r     [0:3];
  reg  [9:0]  mode_r    [0:3];
  reg  [3:0]  wen_r;
  reg  [3:0]  armed_r;
  reg  [3:0]  flag_r;
  reg  [1:0]  def_axis_r;

  // Switch configuration and state
  reg  [15:0] sw_en_r;
  reg  [15:0] sw_lvl_r;
  reg  [15:0] sw_act_r;
  reg  [1:0]  sw_axis_r [0:15];
  reg  [4:0]  sw_out_r  [0:15];
  reg  [31:0] sw_on_r   [0:15];
  reg  [31:0] sw_off_r  [0:15];
  reg  [31:0] out_r;
  reg  [31:0] out_nxt;

  // Servo cycle divider
  reg  [31:0] div_r;
  reg         tick_r;

  // Bus decode
  reg  [31:0] rd_c;
  reg         err_c;
  reg         slverr_r;
  wire        setup_w;
  wire        wr_w;
  wire        is_axis;
  wire        is_sw;
  wire [1:0]  ax_w;
  wire [3:0]  sw_w;
  wire [4:0]  aoff_w;
  wire [3:0]  soff_w;

  // Arm decode
  wire        arm_w;
  wire [1:0]  arm_axis_w;

  // Capture qualification, then switch evaluation temporaries
  reg  [3:0]  trig_c;
  reg  [3:0]  win_c;
  reg  [3:0]  hit_c;
  reg         ps;
  reg         pr;
  reg  [31:0] wpos;
  reg         act;

  assign in_raw  = {registration_in, enc_z, enc_b, enc_a};
  assign setup_w = psel & ~penable;
  assign wr_w    = psel & penable & pwrite;
  assign is_axis = paddr < `AX_END;
  assign is_sw   = (paddr >= `SW_BASE) && (paddr < `SW_END);
  assign ax_w    = paddr[6:5];
  assign sw_w    = paddr[7:4];
  assign aoff_w  = paddr[4:0];
  assign soff_w  = paddr[3:0];

  // Zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & slverr_r;

  // Temporary axis overrides the default one only when its flag is set
  assign arm_w      = wr_w && (paddr == `G_ARM);
  assign arm_axis_w = pwdata[`ARM_TEMP_BIT] ? pwdata[`ARM_AXIS_LO +: 2] : def_axis_r; // [R13]

  // Synchronised levels also serve datum and limit sensing elsewhere
  assign registration_level = sync2_r[15:12]; // [R12]
  assign capture_flag       = flag_r;
  assign switch_out         = out_r;

  // Two-stage synchroniser plus one delay stage for edge detection
  always @(posedge clk_sys) begin
    if (rst) begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
      prev_r  <= 16'h0000;
    end else begin
      sync1_r <= in_raw;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Servo cycle enable pulse
  always @(posedge clk_sys) begin
    if (rst) begin
      div_r  <= `ZERO32;
      tick_r <= 1'b0;
    end else if (div_r >= SERVO_LAST) begin
      div_r  <= `ZERO32;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end

  // Configuration writes; read-only and unmapped words ignore writes
  always @(posedge clk_sys) begin
    if (rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        units_r[i]  <= `UNITS_RST;
        wdist_r[i]  <= `ZERO32;
        wopen_r[i]  <= `ZERO32;
        wclose_r[i] <= `ZERO32;
      end
      for (i = 0; i < 16; i = i + 1) begin
        sw_axis_r[i] <= 2'h0;
        sw_out_r[i]  <= 5'h00;
        sw_on_r[i]   <= `ZERO32;
        sw_off_r[i]  <= `ZERO32;
      end
      wen_r      <= 4'h0;
      sw_en_r    <= 16'h0000;
      sw_lvl_r   <= 16'h0000;
      def_axis_r <= 2'h0;
    end else if (wr_w) begin
      if (is_axis) begin
        if (aoff_w == `AX_UNITS) begin
          units_r[ax_w] <= pwdata;
        end else if (aoff_w == `AX_WDIST) begin
          wdist_r[ax_w] <= pwdata;
        end else if (aoff_w == `AX_WEN) begin
          wen_r[ax_w] <= pwdata[0];
        end else if (aoff_w == `AX_WOPEN) begin
          wopen_r[ax_w] <= pwdata;
        end else if (aoff_w == `AX_WCLOSE) begin
          wclose_r[ax_w] <= pwdata;
        end
      end else if (paddr == `G_DEFAXIS) begin
        def_axis_r <= pwdata[1:0];
      end else if (is_sw) begin
        if (soff_w == `SW_CTRL) begin
          sw_en_r[sw_w]   <= pwdata[`SWC_EN];
          sw_lvl_r[sw_w]  <= pwdata[`SWC_LVL]; // [R1]
          sw_axis_r[sw_w] <= pwdata[`SWC_AXIS_LO +: 2]; // [R18]
          sw_out_r[sw_w]  <= pwdata[`SWC_OUT_LO +: 5];
        end else if (soff_w == `SW_ON) begin
          sw_on_r[sw_w] <= pwdata;
        end else if (soff_w == `SW_OFF) begin
          sw_off_r[sw_w] <= pwdata;
        end
      end
    end
  end

  // Quadrature counting; user position carries whole units, the rest holds edges
  // Counting in units avoids a divider, at the cost of a remainder register per axis
  // Each process keeps its own loop index so no two processes write one variable
  always @(posedge clk_sys) begin : quad_count
    integer i;
    if (rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        upos_r[i] <= `ZERO32;
        rem_r[i]  <= `ZERO32;
        raw_r[i]  <= `ZERO32;
      end
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        // Exactly one phase changed: a legal edge; both changed is a lost step
        if ((sync2_r[i] ^ prev_r[i]) ^ (sync2_r[4+i] ^ prev_r[4+i])) begin
          if (sync2_r[i] ^ prev_r[4+i]) begin
            raw_r[i] <= raw_r[i] + 32'h00000001; // [R6]
            if (rem_r[i] + 32'h00000001 >= units_r[i]) begin
              rem_r[i] <= `ZERO32; // [R5]
              if (wen_r[i] && (upos_r[i] + 32'h00000001 >= wdist_r[i]))
                upos_r[i] <= `ZERO32;
              else
                upos_r[i] <= upos_r[i] + 32'h00000001;
            end else begin
              rem_r[i] <= rem_r[i] + 32'h00000001;
            end
          end else begin
            raw_r[i] <= raw_r[i] - 32'h00000001; // [R6]
            if (rem_r[i] == `ZERO32) begin
              // Zero units factor behaves as one
              rem_r[i] <= (units_r[i] == `ZERO32) ? `ZERO32 : units_r[i] - 32'h00000001;
              if (wen_r[i] && (upos_r[i] == `ZERO32))
                upos_r[i] <= wdist_r[i] - 32'h00000001;
              else
                upos_r[i] <= upos_r[i] - 32'h00000001;
            end else begin
              rem_r[i] <= rem_r[i] - 32'h00000001;
            end
          end
        end
      end
    end
  end

  // Trigger and window qualification per axis
  always @* begin : qualify
    integer i;
    i      = 0;
    trig_c = 4'h0;
    win_c  = 4'h0;
    hit_c  = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      // Axis i owns registration input i
      case (mode_r[i][`ARM_MODE_LO +: `ARM_BASE_W])
        `MODE_Z_RISE: trig_c[i] = sync2_r[8+i] & ~prev_r[8+i]; // [R16]
        `MODE_Z_FALL: trig_c[i] = ~sync2_r[8+i] & prev_r[8+i]; // [R16]
        `MODE_R_RISE: trig_c[i] = sync2_r[12+i] & ~prev_r[12+i]; // [R11]
        `MODE_R_FALL: trig_c[i] = ~sync2_r[12+i] & prev_r[12+i]; // [R11]
        default:      trig_c[i] = 1'b0;
      endcase
      case (mode_r[i][`ARM_WIN_LO +: 2])
        `WIN_INCL: win_c[i] = ($signed(upos_r[i]) > $signed(wopen_r[i])) &&
                              ($signed(upos_r[i]) < $signed(wclose_r[i])); // [R14]
        `WIN_EXCL: win_c[i] = ($signed(upos_r[i]) < $signed(wopen_r[i])) ||
                              ($signed(upos_r[i]) > $signed(wclose_r[i])); // [R15]
        default:   win_c[i] = 1'b1;
      endcase
      hit_c[i] = armed_r[i] & trig_c[i] & win_c[i]; // [R7]
    end
  end

  // Capture latch; a hit in the arming cycle still sets the flag
  always @(posedge clk_sys) begin : capture_latch
    integer i;
    if (rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        mode_r[i]    <= 10'h000;
        cap_pos_r[i] <= `ZERO32;
      end
      armed_r <= 4'h0;
      flag_r  <= 4'h0;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (hit_c[i]) begin
          cap_pos_r[i] <= upos_r[i]; // [R8] [R10]
          flag_r[i]    <= 1'b1; // [R9]
          armed_r[i]   <= 1'b0; // [R17]
        end else if (arm_w && (arm_axis_w == i[1:0])) begin
          flag_r[i]  <= 1'b0; // [R20]
          armed_r[i] <= 1'b1;
        end
        if (arm_w && (arm_axis_w == i[1:0])) begin
          mode_r[i] <= pwdata[9:0];
          if (hit_c[i])
            armed_r[i] <= 1'b1;
        end
      end
    end
  end

  // Switch evaluation: outputs change only when a switch enters or leaves its span
  always @* begin : switch_eval
    integer i;
    i       = 0;
    out_nxt = out_r;
    ps      = 1'b0;
    pr      = 1'b0;
    wpos    = `ZERO32;
    act     = 1'b0;
    for (i = 0; i < 16; i = i + 1) begin
      wpos = upos_r[sw_axis_r[i]]; // [R5]
      ps   = $signed(wpos) >= $signed(sw_on_r[i]);
      pr   = $signed(wpos) >= $signed(sw_off_r[i]);
      act  = ps & ~pr;
      if (sw_en_r[i]) begin // [R4]
        if (act && !sw_act_r[i])
          out_nxt[sw_out_r[i]] = sw_lvl_r[i]; // [R2]
        else if (!act && sw_act_r[i])
          out_nxt[sw_out_r[i]] = ~sw_lvl_r[i]; // [R3]
      end
    end
  end

  // Switch state sampled once per servo cycle
  // A switch disabled while active leaves its output where it was
  always @(posedge clk_sys) begin : switch_state
    integer i;
    if (rst) begin
      out_r    <= `ZERO32;
      sw_act_r <= 16'h0000;
    end else if (tick_r) begin
      out_r <= out_nxt; // [R19]
      for (i = 0; i < 16; i = i + 1) begin
        if (sw_en_r[i])
          sw_act_r[i] <= ($signed(upos_r[sw_axis_r[i]]) >= $signed(sw_on_r[i])) &&
                         ($signed(upos_r[sw_axis_r[i]]) < $signed(sw_off_r[i]));
        else
          sw_act_r[i] <= 1'b0;
      end
    end
  end

  // Read decode; an unmapped word answers zero with an error
  always @* begin
    rd_c  = `ZERO32;
    err_c = 1'b0;
    if (is_axis) begin
      if (aoff_w == `AX_UNITS) begin
        rd_c = units_r[ax_w];
      end else if (aoff_w == `AX_WDIST) begin
        rd_c = wdist_r[ax_w];
      end else if (aoff_w == `AX_WEN) begin
        rd_c = {31'h00000000, wen_r[ax_w]};
      end else if (aoff_w == `AX_POS) begin
        rd_c = upos_r[ax_w];
      end else if (aoff_w == `AX_WOPEN) begin
        rd_c = wopen_r[ax_w];
      end else if (aoff_w == `AX_WCLOSE) begin
        rd_c = wclose_r[ax_w];
      end else if (aoff_w == `AX_CAPPOS) begin
        rd_c = cap_pos_r[ax_w]; // [R10]
      end else if (aoff_w == `AX_STAT) begin
        rd_c[`ST_FLAG]  = flag_r[ax_w];
        rd_c[`ST_ARMED] = armed_r[ax_w];
      end else begin
        err_c = 1'b1;
      end
    end else if (paddr == `G_DEFAXIS) begin
      rd_c[1:0] = def_axis_r;
    end else if (paddr == `G_ARM) begin
      rd_c[9:0] = mode_r[def_axis_r];
    end else if (paddr == `G_OUTS) begin
      rd_c = out_r;
    end else if ((paddr >= `G_RAW_BASE) && (paddr < `G_RAW_END) && (paddr[1:0] == 2'h0)) begin
      rd_c = raw_r[paddr[3:2]];
    end else if (is_sw) begin
      if (soff_w == `SW_CTRL) begin
        rd_c[`SWC_EN]            = sw_en_r[sw_w];
        rd_c[`SWC_LVL]           = sw_lvl_r[sw_w];
        rd_c[`SWC_AXIS_LO +: 2]  = sw_axis_r[sw_w];
        rd_c[`SWC_OUT_LO +: 5]   = sw_out_r[sw_w];
      end else if (soff_w == `SW_ON) begin
        rd_c = sw_on_r[sw_w];
      end else if (soff_w == `SW_OFF) begin
        rd_c = sw_off_r[sw_w];
      end else begin
        err_c = 1'b1;
      end
    end else begin
      err_c = 1'b1;
    end
  end

  // Read data and error captured in the setup cycle, shown in the access cycle
  always @(posedge clk_sys) begin
    if (rst) begin
      prdata   <= `ZERO32;
      slverr_r <= 1'b0;
    end else if (setup_w) begin
      prdata   <= pwrite ? `ZERO32 : rd_c;
      slverr_r <= err_c;
    end
  end

endmodule // axis_position_capture_and_switch

// *** enc_model.sv ***
// Behavioural encoder, index marker and registration sensor pins for four axes
`timescale 1ns/1ps

module enc_model (
  input  wire       clk_sys,
  output reg  [3:0] enc_a,
  output reg  [3:0] enc_b,
  output reg  [3:0] enc_z,
  output reg  [3:0] registration_in
);
  reg [1:0] ph [0:3];
  integer   i;

  // Pins start low, quadrature phase at zero
  initial begin
    for (i = 0; i < 4; i = i + 1) ph[i] = 2'h0;
    enc_a = 4'h0;
    enc_b = 4'h0;
    enc_z = 4'h0;
    registration_in = 4'h0;
  end

  // Gray sequence gives one edge a step; spaced so the 3-stage input path sees each one
  task step(input int ax, input bit up, input int n);
    int k;
    for (k = 0; k < n; k++) begin
      @(posedge clk_sys);
      ph[ax] = up ? ph[ax] + 2'h1 : ph[ax] - 2'h1;
      enc_a[ax] <= ph[ax][1] ^ ph[ax][0];
      enc_b[ax] <= ph[ax][1];
      repeat (3) @(posedge clk_sys);
    end
  endtask

  // Set index marker or registration level, then hold it long enough to be seen
  task pin(input bit z, input int ax, input bit v);
    @(posedge clk_sys);
    if (z) enc_z[ax] <= v;
    else registration_in[ax] <= v;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule // enc_model

// *** tb_axis_position_capture_and_switch.sv ***
// Self-checking bench for the axis capture and switch block
`timescale 1ns/1ps
`include "axis_capture_map.vh"

module tb_axis_position_capture_and_switch;
  reg         clk_sys, rst, psel, penable, pwrite, err;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, q;
  wire [31:0] prdata, switch_out;
  wire        pready, pslverr;
  wire [3:0]  enc_a, enc_b, enc_z, registration_in, registration_level, capture_flag;
  int         miscompares, tests_run, m, ax, k, p;
  int         edges[4], units[4];
  int         wm[4] = '{259, 771, 771, 259};

  axis_position_capture_and_switch #(.SERVO_CYCLES(8)) axis_position_capture_and_switch_i (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z), .registration_in(registration_in),
    .registration_level(registration_level), .capture_flag(capture_flag),
    .switch_out(switch_out));
  enc_model enc_model_i (.clk_sys(clk_sys), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z),
    .registration_in(registration_in));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge
  task apb(input bit w, input [11:0] a, input [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin miscompares++; conclude; end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input [11:0] a, input [31:0] d); apb(1'b1, a, d); endtask
  task rd(input [11:0] a, input [31:0] e); apb(1'b0, a, 32'h0); chk(q, e); endtask

  // Bounded wait for a flag (o=0) or output (o=1) bit to reach e
  task wt(input bit o, input int b, input bit e);
    int n;
    for (n = 0; n < 40 && (o ? switch_out[b] : capture_flag[b]) !== e; n++) @(posedge clk_sys);
    chk({31'h0, o ? switch_out[b] : capture_flag[b]}, {31'h0, e});
    if (n == 40) conclude;
  endtask

  task mv(input int a, input int n);
    enc_model_i.step(a, n > 0, n > 0 ? n : -n);
    edges[a] += n;
    repeat (4) @(posedge clk_sys);
  endtask

  function automatic int upos(input int a); return edges[a] / units[a]; endfunction

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    for (k = 0; k < 4; k++) begin edges[k] = 0; units[k] = 1; end
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset state, a refused hole read and an ignored write to a read-only word
    rd(`AX_UNITS, `UNITS_RST); rd(`AX_POS, 0); rd(`G_OUTS, 0);
    apb(1'b0, 12'h0a0, 0); chk({31'h0, err}, 1); chk(q, 0);
    wr(`AX_CAPPOS, 32'h00000055); rd(`AX_CAPPOS, 0);
    $display("register test done");
    // Four counts a line, scaled by units
    wr(12'h020, 2); units[1] = 2;
    mv(0, 4); mv(1, 8);
    rd(`G_RAW_BASE, 4); rd(`G_RAW_BASE + 12'h004, 8);
    rd(12'h020 + `AX_POS, 4);
    $display("count test done");
    // Every base mode, one axis each, last one through the default axis
    for (m = 1; m < 5; m++) begin
      ax = m - 1;
      mv(ax, 4 * m);
      if (m % 2 == 0) enc_model_i.pin(m < 3, ax, 1'b1);
      if (m == 4) begin wr(`G_DEFAXIS, 3); wr(`G_ARM, 4); end
      else wr(`G_ARM, m | (ax << 12) | 32'h10000);
      rd(ax * 32 + `AX_STAT, 2);
      enc_model_i.pin(m < 3, ax, m % 2);
      wt(1'b0, ax, 1'b1);
      p = upos(ax);
      rd(ax * 32 + `AX_CAPPOS, p);
      mv(ax, 4);
      enc_model_i.pin(m < 3, ax, ~m[0]);
      enc_model_i.pin(m < 3, ax, m[0]);
      rd(ax * 32 + `AX_CAPPOS, p);
      rd(ax * 32 + `AX_STAT, 1);
    end
    chk({28'h0, registration_level}, {28'h0, registration_in});
    $display("capture test done");
    // Inclusive and exclusive windows around the axis 0 position
    for (k = 0; k < 4; k++) begin
      wr(`AX_WOPEN, k < 2 ? 2 : upos(0) + 1); wr(`AX_WCLOSE, 100);
      wr(`G_ARM, wm[k] | 32'h10000);
      rd(`AX_STAT, 2);
      enc_model_i.pin(1'b0, 0, 1'b0);
      enc_model_i.pin(1'b0, 0, 1'b1);
      repeat (12) @(posedge clk_sys);
      chk({31'h0, capture_flag[0]}, {31'h0, k == 0 || k == 2});
    end
    $display("window test done");
    // Highest switch on axis 2 drives output 11 across its span
    p = upos(2);
    wr(`SW_BASE + 12'h0f0 + `SW_ON, p + 2); wr(`SW_BASE + 12'h0f0 + `SW_OFF, p + 4);
    wr(`SW_BASE + 12'h0f0, 32'h00000b23);
    mv(2, 2); wt(1'b1, 11, 1'b1);
    rd(`G_OUTS, 32'h00000800);
    mv(2, 2); wt(1'b1, 11, 1'b0);
    wr(`SW_BASE + 12'h0f0, 32'h00000b22);
    mv(2, -1);
    repeat (20) @(posedge clk_sys);
    chk(switch_out, 32'h0);
    // Level zero: entering drives 0, leaving drives 1; a tick must see the span first
    wr(`SW_BASE + 12'h0f0, 32'h00000b21);
    repeat (10) @(posedge clk_sys);
    mv(2, 1); wt(1'b1, 11, 1'b1);
    $display("switch test done");
    // Axis 3 stands at 20; with wrap distance 22, up 3 gives 1 and down 2 gives 21
    wr(12'h060 + `AX_WDIST, 22); wr(12'h060 + `AX_WEN, 1);
    mv(3, 3); rd(12'h060 + `AX_POS, 1);
    mv(3, -2); rd(12'h060 + `AX_POS, 21);
    $display("wrap test done");
    conclude;
  end
endmodule // tb_axis_position_capture_and_switch

bind axis_position_capture_and_switch axis_capture_checker #(.SERVO_CYCLES(SERVO_CYCLES))
  axis_capture_checker_i (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z),
  .registration_in(registration_in), .registration_level(registration_level),
  .capture_flag(capture_flag), .switch_out(switch_out));
